// ---- core/itc_pkg.sv ----
// itc_pkg: constants, state codes and carriers of the i2c transmit controller.
// assumes: one 125 MHz clock, ahb-lite register access, byte address = index * 4.
package itc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is index * 4)
  localparam logic [11:0] IDX_STATUS  = 12'h0f50;
  localparam logic [11:0] IDX_DATA    = 12'h0f51;
  localparam logic [11:0] IDX_CONTROL = 12'h0f52;
  localparam logic [11:0] IDX_RATE_HI = 12'h0f53;
  localparam logic [11:0] IDX_RATE_LO = 12'h0f54;

  // i2c_control field positions
  localparam int CTL_EN    = 7;
  localparam int CTL_START = 6;
  localparam int CTL_STOP  = 5;
  localparam int CTL_TMR_IE = 4;
  localparam int CTL_TX_IE  = 3;
  localparam int CTL_NAK   = 2;
  localparam int CTL_FLUSH = 1;
  localparam int CTL_FILT  = 0;

  // status field positions
  localparam int STA_EMPTY = 7;
  localparam int STA_ACK   = 6;
  localparam int STA_BUSY  = 5;
  localparam int STA_SCL   = 4;
  localparam int STA_SDA   = 3;
  localparam int STA_NOACK = 1;
  localparam int STA_TMR   = 0;

  // reset values and counts
  localparam logic [7:0]  RATE_HI_RST = 8'h00;
  localparam logic [7:0]  RATE_LO_RST = 8'hff;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [15:0] TICK_LIMIT  = 16'h0001;

  // bus state, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_RSTA = 10'b00_0000_0010,
    ST_STA  = 10'b00_0000_0100,
    ST_BLO  = 10'b00_0000_1000,
    ST_BHI  = 10'b00_0001_0000,
    ST_ALO  = 10'b00_0010_0000,
    ST_AHI  = 10'b00_0100_0000,
    ST_HOLD = 10'b00_1000_0000,
    ST_PLO  = 10'b01_0000_0000,
    ST_PHI  = 10'b10_0000_0000
  } itc_state_e;

  // open-drain line drive; oe low means pulling the line
  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } itc_drv_s;

  // complete state of the controller
  typedef struct packed {
    itc_state_e  st;
    logic [7:0]  sh;
    logic [2:0]  bits;
    logic [15:0] cnt;
    logic        en;
    logic        start;
    logic        stop;
    logic        tmr_ie;
    logic        tx_ie;
    logic        nak;
    logic        filt;
    logic        empty;
    logic        ack;
    logic        nacki;
    logic        tflag;
    logic [7:0]  data;
    logic [7:0]  rhi;
    logic [7:0]  rlo;
    logic [2:0]  sda_s;
    logic [2:0]  scl_s;
    logic        sda_l;
    logic        scl_l;
    logic [1:0]  sda_f;
    logic [1:0]  scl_f;
    logic        sda_fl;
    logic        scl_fl;
    logic        wr;
    logic [11:0] widx;
    logic [31:0] rdata;
    logic        rdy;
    logic        irq;
    logic        scl_lo;
    logic        sda_lo;
  } itc_regs_s;

  localparam itc_regs_s REGS_RST = '{
    st: ST_IDLE, empty: 1'b1, rhi: RATE_HI_RST, rlo: RATE_LO_RST,
    sda_s: 3'b111, scl_s: 3'b111, sda_l: 1'b1, scl_l: 1'b1,
    sda_f: 2'b11, scl_f: 2'b11, sda_fl: 1'b1, scl_fl: 1'b1,
    rdy: 1'b1, default: '0
  };

endpackage

// ---- core/itc_core.sv ----
// itc_core: single-master i2c write controller with ahb-lite registers.
// assumes: scl and sda are open-drain wires pulled up outside; inputs are async.

module itc_core
  import itc_pkg::*;
(
  input  wire logic        clock,     // system clock
  input  wire logic        rstn,      // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write not read
  input  wire logic [2:0]  hsize,     // transfer size
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic      [31:0] hrdata,    // read data
  output logic             hreadyout, // slave ready
  output logic             hresp,     // always okay
  input  wire logic        scl_in,    // scl line level
  input  wire logic        sda_in,    // sda line level
  output itc_drv_s         line,      // open-drain drives
  output logic             irq        // interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  itc_regs_s   r;
  itc_regs_s   n;
  logic        tick;
  logic        sda_v;
  logic        scl_v;
  logic        hi_ph;
  logic        apv;
  logic        wr_ctl;
  logic        wr_dat;
  logic        wr_sta;
  logic [7:0]  w;
  logic [15:0] rate;
  logic [7:0]  ctl_rd;
  logic [7:0]  sta_rd;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = r;
    w = hwdata[7:0];
    rate = {r.rhi, r.rlo};
    apv = hsel & htrans[1] & hready;
    wr_ctl = r.wr & (r.widx == IDX_CONTROL);
    wr_dat = r.wr & (r.widx == IDX_DATA);
    wr_sta = r.wr & (r.widx == IDX_STATUS);

    // input synchronisers: level moves once stages two and three agree
    n.sda_s = {r.sda_s[1:0], sda_in};
    n.scl_s = {r.scl_s[1:0], scl_in};
    if (r.sda_s[1] == r.sda_s[2]) begin
      n.sda_l = r.sda_s[2];
    end
    if (r.scl_s[1] == r.scl_s[2]) begin
      n.scl_l = r.scl_s[2];
    end

    // glitch filter: three equal samples, three cycles later
    n.sda_f = {r.sda_f[0], r.sda_l};
    n.scl_f = {r.scl_f[0], r.scl_l};
    if ((r.sda_l == r.sda_f[0]) && (r.sda_f[0] == r.sda_f[1])) begin
      n.sda_fl = r.sda_f[1];
    end
    if ((r.scl_l == r.scl_f[0]) && (r.scl_f[0] == r.scl_f[1])) begin
      n.scl_fl = r.scl_f[1];
    end
    sda_v = r.filt ? r.sda_fl : r.sda_l;
    scl_v = r.filt ? r.scl_fl : r.scl_l;

    // phase counter; high phases wait for the line to be high
    hi_ph = (r.st == ST_BHI) | (r.st == ST_AHI) | (r.st == ST_PHI)
          | (r.st == ST_STA) | (r.st == ST_RSTA);
    tick = (r.cnt <= TICK_LIMIT) & ~(r.en & hi_ph & ~scl_v);
    if (r.en & hi_ph & ~scl_v) begin
      n.cnt = r.cnt;
    end else if (tick) begin
      n.cnt = rate;
    end else begin
      n.cnt = r.cnt - 16'h0001;
    end

    // timer use while the controller is off
    if (~r.en & r.tmr_ie & tick) begin
      n.tflag = 1'b1;
    end else if (wr_sta & w[STA_TMR]) begin
      n.tflag = 1'b0;
    end

    // register writes that store values or clear flags
    if (r.wr && (r.widx == IDX_RATE_HI)) begin
      n.rhi = w;
    end
    if (r.wr && (r.widx == IDX_RATE_LO)) begin
      n.rlo = w;
    end
    if (wr_dat) begin
      n.data  = w;
      n.empty = 1'b0;
    end
    if (wr_ctl) begin
      n.en     = w[CTL_EN];
      n.tmr_ie = w[CTL_TMR_IE];
      n.tx_ie  = w[CTL_TX_IE];
      n.filt   = w[CTL_FILT];
      // flush drops the queued byte as well as marking empty
      if (w[CTL_FLUSH]) begin
        n.data  = 8'h00;
        n.empty = 1'b1;
      end
    end

    // bus sequencer, single master, no arbitration
    if (~r.en) begin
      n.st    = ST_IDLE;
      n.start = 1'b0;
      n.stop  = 1'b0;
      n.nak   = 1'b0;
    end else if (tick) begin
      case (r.st)
        ST_IDLE: begin
          if (r.stop) begin
            n.stop = 1'b0;
          end else if (r.start & ~r.empty) begin
            n.st = ST_STA;
          end
        end
        ST_RSTA: begin
          n.st = ST_STA;
        end
        ST_STA: begin
          n.start = 1'b0;
          n.sh    = r.data;
          n.bits  = 3'h0;
          n.st    = ST_BLO;
        end
        ST_BLO: begin
          n.st = ST_BHI;
        end
        ST_BHI: begin
          n.sh   = {r.sh[6:0], 1'b0};
          n.bits = r.bits + 3'h1;
          if (r.bits == 3'h0) begin
            n.empty = 1'b1;
          end
          n.st = (r.bits == LAST_BIT) ? ST_ALO : ST_BLO;
        end
        ST_ALO: begin
          n.st = ST_AHI;
        end
        ST_AHI: begin
          n.ack = ~sda_v;
          if (sda_v & ~r.stop) begin
            n.nacki = 1'b1;
          end
          n.st = ST_HOLD;
        end
        ST_HOLD: begin
          if (r.stop) begin
            n.st = ST_PLO;
          end else if (r.start & ~r.empty & ~r.nacki) begin
            n.st = ST_RSTA;
          end else if (~r.empty & ~r.nacki) begin
            n.sh   = r.data;
            n.bits = 3'h0;
            n.st   = ST_BLO;
          end
        end
        ST_PLO: begin
          n.st = ST_PHI;
        end
        ST_PHI: begin
          n.stop  = 1'b0;
          n.nacki = 1'b0;
          n.st    = ST_IDLE;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end

    // software sets of start, stop and nak win over hardware clears
    if (wr_ctl & w[CTL_EN]) begin
      if (w[CTL_START]) begin
        n.start = 1'b1;
      end
      if (w[CTL_STOP]) begin
        n.stop = 1'b1;
      end
      if (w[CTL_NAK]) begin
        n.nak = 1'b1;
      end
    end

    // registered line drives
    n.scl_lo = (n.st == ST_BLO) | (n.st == ST_ALO) | (n.st == ST_HOLD)
             | (n.st == ST_PLO);
    n.sda_lo = (n.st == ST_STA) | (n.st == ST_PLO) | (n.st == ST_PHI)
             | (((n.st == ST_BLO) | (n.st == ST_BHI)) & ~n.sh[7]);

    // interrupt request
    n.irq = (n.tx_ie & n.empty) | n.nacki | n.tflag;

    // ahb-lite: address phase captured, write done in data phase
    ctl_rd = {r.en, r.start, r.stop, r.tmr_ie, r.tx_ie, r.nak, 1'b0, r.filt};
    sta_rd = 8'h00;
    sta_rd[STA_EMPTY] = r.empty;
    sta_rd[STA_ACK]  = r.ack;
    sta_rd[STA_BUSY] = (r.st != ST_IDLE);
    sta_rd[STA_SCL]  = scl_v;
    sta_rd[STA_SDA]  = sda_v;
    sta_rd[STA_NOACK] = r.nacki;
    sta_rd[STA_TMR]  = r.tflag;
    n.wr = apv & hwrite;
    if (apv) begin
      n.widx = haddr[13:2];
    end
    n.rdy = 1'b1;
    if (apv & ~hwrite) begin
      case (haddr[13:2])
        IDX_STATUS:  n.rdata = {24'h00_0000, sta_rd};
        IDX_DATA:    n.rdata = {24'h00_0000, r.data};
        IDX_CONTROL: n.rdata = {24'h00_0000, ctl_rd};
        IDX_RATE_HI: n.rdata = {24'h00_0000, r.rhi};
        IDX_RATE_LO: n.rdata = {24'h00_0000, r.rlo};
        default:     n.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, except hresp, scl_out and sda_out, which are tied to zero
  assign hrdata        = r.rdata;
  assign hreadyout     = r.rdy;
  assign hresp         = 1'b0;
  assign irq           = r.irq;
  assign line.scl_out  = 1'b0;
  assign line.scl_oe_n = ~r.scl_lo;
  assign line.sda_out  = 1'b0;
  assign line.sda_oe_n = ~r.sda_lo;

endmodule

// ---- dv/itc_core_properties.sv ----
// itc_core_properties: bus and line timing checks on itc_core ports.
// assumes: bench rate of ten cycles per scl phase.
module itc_core_properties
  import itc_pkg::*;
(
  input wire logic        clock,     // clock
  input wire logic        rstn,      // reset
  input wire logic        hsel,      // select
  input wire logic [31:0] haddr,     // address
  input wire logic [1:0]  htrans,    // transfer
  input wire logic        hwrite,    // write
  input wire logic        hready,    // ready in
  input wire logic [31:0] hrdata,    // read data
  input wire logic        hreadyout, // ready out
  input wire itc_drv_s    line,      // line drives
  input wire logic        irq        // interrupt
);
  logic rd_ctl_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // marks the data phase of a control read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rd_ctl_r <= 1'b0;
    else rd_ctl_r <= hsel && htrans[1] && hready && !hwrite && haddr[13:2] == IDX_CONTROL;
  end

  //////////////////////////////////////////
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_rd_upper_zero: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper bits");
  a_flush_reads_zero: assert property (rd_ctl_r |-> !hrdata[CTL_FLUSH])
    else $error("flush read one");
  a_reset_idle: assert property ($rose(rstn) |-> line.scl_oe_n && line.sda_oe_n && !irq)
    else $error("not idle after reset");
  a_drive_low: assert property (!line.scl_out && !line.sda_out) else $error("drive high");
  a_scl_low_min: assert property ($fell(line.scl_oe_n) |-> !line.scl_oe_n [*3])
    else $error("scl low short");
  a_start_then_clock: assert property ($fell(line.sda_oe_n) && line.scl_oe_n |-> ##[1:40] !line.scl_oe_n)
    else $error("no clock after start");
  a_stop_then_idle: assert property ($rose(line.sda_oe_n) && line.scl_oe_n |-> (line.sda_oe_n && line.scl_oe_n) [*3])
    else $error("bus busy after stop");
endmodule

bind itc_core itc_core_properties chk_u (
  .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .line(line), .irq(irq)
);

// ---- dv/itc_slave_model.sv ----
// itc_slave_model: i2c slave that takes bytes and acks or refuses them.
// assumes: open-drain wires with pull-ups joined in the bench.
module itc_slave_model (
  input  wire logic  nack,  // refuse bytes
  input  wire logic  scl,   // scl wire
  input  wire logic  sda,   // sda wire
  output logic       pull,  // pulls sda low
  output logic [7:0] first, // first byte
  output logic [7:0] last,  // latest byte
  output int         count  // bytes since start
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bitc = 0;
  logic [7:0] sh = 8'h00;

  initial pull = 1'b0;
  // start condition restarts framing
  // look at scl after the step settles: scl may fall in the same step
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      bitc = 0;
      count = 0;
    end
  end
  // bits taken while scl is high, msb first
  always @(posedge scl) if (bitc < 8) begin
    sh = {sh[6:0], sda};
    bitc++;
  end
  // ack in the ninth low phase, released after it
  always @(negedge scl) begin
    if (bitc == 8) begin
      pull = ~nack;
      if (count == 0) first = sh;
      last = sh;
      count++;
      bitc = 9;
    end else if (bitc == 9) begin
      pull = 1'b0;
      bitc = 0;
    end
  end
endmodule

// ---- dv/itc_core_tb.sv ----
// itc_core_tb: register, transfer and timer tests of itc_core.
// assumes: slave model on pulled-up wires, rate of ten cycles.
module itc_core_tb import itc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, nack = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic        hreadyout, hresp, irq, pull;
  logic [7:0]  fst, lst, v, d;
  logic [7:0]  seed = 8'h3c;
  int          nb, t0, cyc = 0, miscompares = 0, checked = 0;
  itc_drv_s    line;
  wire         scl_w = line.scl_oe_n;
  wire         sda_w = line.sda_oe_n & ~pull;

  // clock and cycle count
  always #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  itc_core dut_u (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w),
    .sda_in(sda_w), .line(line), .irq(irq)
  );
  itc_slave_model slv_u (
    .nack(nack), .scl(scl_w), .sda(sda_w), .pull(pull), .first(fst),
    .last(lst), .count(nb)
  );

  //////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g, input string n);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single ahb transfer; read byte lands in v
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0000, i, 2'h0};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    v = hrdata[7:0];
  endtask
  task automatic wait_irq(input logic e);
    for (int n = 0; n < 3000 && irq !== e; n++) @(posedge clock);
    chk({7'h00, e}, {7'h00, irq}, "irq");
  endtask
  task automatic load(input logic [7:0] b);
    bus(1'b1, IDX_DATA, b);
    wait_irq(1'b0);
  endtask
  task automatic wait_stop();
    for (int n = 0; n < 400; n++) begin
      bus(1'b0, IDX_CONTROL, 8'h00);
      if (!v[CTL_STOP]) break;
    end
    chk(8'h00, v & 8'h20, "stop");
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(8'h98, v, "status");
    chk(8'h00, {7'h00, hresp}, "hresp");
    bus(1'b0, IDX_RATE_LO, 8'h00);
    chk(RATE_LO_RST, v, "rate_lo");
    bus(1'b0, 12'hf5f, 8'h00);
    chk(8'h00, v, "unmapped");
    bus(1'b1, IDX_RATE_HI, seed);
    bus(1'b0, IDX_RATE_HI, 8'h00);
    chk(seed, v, "rate_hi");
    bus(1'b1, IDX_RATE_HI, 8'h00);
    bus(1'b1, IDX_RATE_LO, 8'h0a);
    $display("test registers done");
    // seven-bit write of two random bytes, filters on
    bus(1'b1, IDX_CONTROL, 8'h81);
    bus(1'b1, IDX_CONTROL, 8'h89);
    wait_irq(1'b1);
    seed = lfsr(seed);
    d = {seed[7:1], 1'b0};
    load(d);
    bus(1'b1, IDX_CONTROL, 8'hc9);
    for (int k = 0; k < 2; k++) begin
      wait_irq(1'b1);
      seed = lfsr(seed);
      load(seed);
    end
    wait_irq(1'b1);
    bus(1'b1, IDX_CONTROL, 8'ha1);
    wait_stop();
    chk(d, fst, "addr");
    chk(seed, lst, "data");
    chk(8'h03, 8'(nb), "count");
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(8'h40, v & 8'h42, "ack");
    $display("test write done");
    // refused address, stop queued early then late
    nack <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, IDX_CONTROL, 8'h88);
      seed = lfsr(seed);
      d = {5'h1e, seed[1:0], 1'b0};
      load(d);
      bus(1'b1, IDX_CONTROL, 8'hc8);
      wait_irq(1'b1);
      if (e == 0) begin
        bus(1'b1, IDX_DATA, seed);
        bus(1'b1, IDX_CONTROL, 8'ha2);
      end else begin
        bus(1'b1, IDX_CONTROL, 8'h80);
        wait_irq(1'b0);
        wait_irq(1'b1);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk(8'h02, v & 8'h42, "nack_flag");
        bus(1'b1, IDX_CONTROL, 8'ha2);
      end
      wait_stop();
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(8'h80, v & 8'hc2, "after_stop");
      chk(8'h00, {7'h00, irq}, "irq_quiet");
      chk(d, fst, "addr10");
      chk(8'h01, 8'(nb), "nack_count");
      bus(1'b0, IDX_DATA, 8'h00);
      chk(8'h00, v, "flushed");
    end
    $display("test nack done");
    // rate generator as a timer, interrupt on and off
    nack <= 1'b0;
    bus(1'b1, IDX_CONTROL, 8'h10);
    wait_irq(1'b1);
    t0 = cyc;
    bus(1'b1, IDX_STATUS, 8'h01);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk(8'h0a, 8'(cyc - t0), "interval");
    bus(1'b1, IDX_CONTROL, 8'h00);
    bus(1'b1, IDX_STATUS, 8'h01);
    repeat (30) @(posedge clock);
    chk(8'h00, {7'h00, irq}, "timer_off");
    $display("test timer done");
    end_sim();
  end
endmodule
